// [src/ccm_cfg.svh]
`ifndef CCM_CFG_SVH
`define CCM_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define CCM_OFF_CTRL      12'h000
`define CCM_OFF_CAP_LOW   12'h004
`define CCM_OFF_CAP_HIGH  12'h008
`define CCM_OFF_FLAG      12'h00c
`define CCM_OFF_ENABLE    12'h010
`define CCM_OFF_STATUS    12'h014

// ****************************************************************
// Field positions
// ****************************************************************
`define CCM_MODE_HI       3
`define CCM_MODE_LO       0
`define CCM_GRP_HI        3
`define CCM_GRP_LO        2
`define CCM_DUTY_HI       5
`define CCM_DUTY_LO       4
`define CCM_STORE_HI      5
`define CCM_FLAG_BIT      0
`define CCM_ST_PIN_BIT    0
`define CCM_ST_OUT_BIT    1
`define CCM_ST_PRE_HI     7
`define CCM_ST_PRE_LO     4

// ****************************************************************
// Mode codes and groups
// ****************************************************************
`define CCM_M_CAP_FALL    4'h4
`define CCM_M_CAP_RISE    4'h5
`define CCM_M_CAP_4       4'h6
`define CCM_M_CAP_16      4'h7
`define CCM_M_CMP_SET     4'h8
`define CCM_M_CMP_CLR     4'h9
`define CCM_M_CMP_SW      4'ha
`define CCM_M_CMP_SPEV    4'hb
`define CCM_M_OFF         4'h0
`define CCM_GRP_OFF       2'h0
`define CCM_GRP_CAP       2'h1
`define CCM_GRP_CMP       2'h2
`define CCM_GRP_PWM       2'h3

// ****************************************************************
// Counts and reset values
// ****************************************************************
`define CCM_PRE4_LAST     4'h3
`define CCM_PRE16_LAST    4'hf
`define CCM_PRE_STEP      4'h1
`define CCM_PRE_RST       4'h0
`define CCM_CTRL_RST      6'h00
`define CCM_DUTY_ZERO     10'h000
`define CCM_RD_PAD        24'h000000
`define CCM_RD_ZERO       32'h00000000

`endif

// [src/ccm_pkg.sv]
package ccm_pkg;

  // ****************************************************************
  // Bus carriers
  // ****************************************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ccm_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ccm_apb_rsp_s;

  // ****************************************************************
  // Mode classes
  // ****************************************************************
  typedef enum logic [1:0] {
    CCM_CL_OFF,
    CCM_CL_CAPTURE,
    CCM_CL_COMPARE,
    CCM_CL_PWM
  } ccm_class_e;

  // ****************************************************************
  // Whole block state
  // ****************************************************************
  typedef struct packed {
    logic [5:0]   ctrl;
    logic [15:0]  cap;
    logic         irq_flag;
    logic         irq_en;
    logic         pin_meta;
    logic         pin_sync;
    logic         pin_prev;
    logic [3:0]   presc;
    logic         cmp_out;
    logic         pwm_out;
    logic [9:0]   duty_latch;
    logic         pin_out;
    logic         pin_oe;
    logic         tmr_rst;
    logic         adc_go;
    ccm_apb_rsp_s rsp;
  } ccm_state_s;

endpackage

// [src/ccm_top.sv]
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "ccm_cfg.svh"

// Contract
// - Mode 0000 turns the unit off and clears its internal state and prescaler.
// - Modes 0100-0111 capture on falling, rising, fourth rising, sixteenth rising edge.
// - Mode 1000 drives compare output high on match and sets the flag.
// - Mode 1001 drives compare output low on match and sets the flag.
// - Mode 1010 match sets only the flag, pin untouched.
// - Mode 1011 match sets flag, resets timer, starts conversion if enabled.
// - Modes 11xx are pulse width; control bits 5-4 are duty low bits.
// - Control bits 7-6 read zero; duty bits ignored outside pulse width.
// - A qualified capture event copies the full 16-bit timer value.
// - Each capture sets the flag; only software clears it.
// - A newer capture overwrites an unread held value.
// - Edge detector watches the pin level even while the pin is driven.
// - Prescaler cleared when off, outside capture mode, and on reset.
// - Direct prescale change keeps the counter; software writes zero first.
// - Capture and compare share one 16-bit timer; pulse width another.
// - Compare modes compare the capture pair with the timer continuously.
module ccm_top (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Register bus
  input  wire ccm_pkg::ccm_apb_req_s apb_req,
  output      ccm_pkg::ccm_apb_rsp_s apb_rsp,
  // Shared time bases
  input  wire logic [15:0]           shared_timer_count,
  input  wire logic [9:0]            pulse_time_base,
  input  wire logic                  pulse_period_match,
  output      logic                  shared_timer_reset,
  // Converter
  input  wire logic                  adc_enabled,
  output      logic                  adc_start,
  // Event pin
  input  wire logic                  event_pin_in,
  input  wire logic                  pin_direction_bit,
  input  wire logic                  port_latch_value,
  output      logic                  event_pin_out,
  output      logic                  event_pin_oe,
  // Flag and enable levels
  output      logic                  unit_irq_flag,
  output      logic                  unit_irq_enable
);
  import ccm_pkg::*;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic ccm_class_e mode_class(input logic [5:0] ctrl);
    ccm_class_e cl;
    cl = CCM_CL_OFF;
    unique case (ctrl[`CCM_GRP_HI:`CCM_GRP_LO])
      `CCM_GRP_OFF: cl = CCM_CL_OFF;
      `CCM_GRP_CAP: cl = CCM_CL_CAPTURE;
      `CCM_GRP_CMP: cl = CCM_CL_COMPARE;
      `CCM_GRP_PWM: cl = CCM_CL_PWM;
    endcase
    return cl;
  endfunction

  function automatic logic [3:0] mode_of(input logic [5:0] ctrl);
    return ctrl[`CCM_MODE_HI:`CCM_MODE_LO];
  endfunction

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  ccm_state_s s;
  ccm_state_s next_s;

  logic       bus_setup;
  logic       bus_commit;
  logic       wr_commit;
  logic       rise;
  logic       fall;
  logic       cap_event;
  logic       cmp_match;
  logic [9:0] duty_word;
  logic [7:0] rd_byte;
  logic       rd_hit;
  ccm_class_e cl;
  logic [3:0] mode;

  always_comb begin
    next_s     = s;
    cl         = mode_class(s.ctrl);
    mode       = mode_of(s.ctrl);
    bus_setup  = apb_req.psel & apb_req.penable & ~s.rsp.pready;
    bus_commit = apb_req.psel & apb_req.penable & s.rsp.pready;
    wr_commit  = bus_commit & apb_req.pwrite;

    // ****************************************************************
    // Pin synchroniser and edge detector
    // ****************************************************************
    next_s.pin_meta = event_pin_in;
    next_s.pin_sync = s.pin_meta;
    next_s.pin_prev = s.pin_sync;
    rise = s.pin_sync & ~s.pin_prev;
    fall = ~s.pin_sync & s.pin_prev;

    // ****************************************************************
    // Capture qualification and prescaler
    // ****************************************************************
    cap_event = 1'b0;
    if (cl == CCM_CL_CAPTURE) begin
      unique case (mode)
        `CCM_M_CAP_FALL: cap_event = fall;
        `CCM_M_CAP_RISE: cap_event = rise;
        `CCM_M_CAP_4: begin
          if (rise) begin
            cap_event    = s.presc[1:0] == `CCM_PRE4_LAST;
            next_s.presc = cap_event ? `CCM_PRE_RST : s.presc + `CCM_PRE_STEP;
          end
        end
        `CCM_M_CAP_16: begin
          if (rise) begin
            cap_event    = s.presc == `CCM_PRE16_LAST;
            next_s.presc = s.presc + `CCM_PRE_STEP;
          end
        end
      endcase
    end else begin
      next_s.presc = `CCM_PRE_RST;
    end

    // ****************************************************************
    // Compare against the shared timer
    // ****************************************************************
    cmp_match      = (cl == CCM_CL_COMPARE) && (s.cap == shared_timer_count);
    next_s.tmr_rst = 1'b0;
    next_s.adc_go  = 1'b0;
    if (cmp_match) begin
      unique case (mode)
        `CCM_M_CMP_SET: next_s.cmp_out = 1'b1;
        `CCM_M_CMP_CLR: next_s.cmp_out = 1'b0;
        `CCM_M_CMP_SW: next_s.cmp_out = s.cmp_out;
        `CCM_M_CMP_SPEV: begin
          next_s.tmr_rst = 1'b1;
          next_s.adc_go  = adc_enabled;
        end
      endcase
    end

    // ****************************************************************
    // Pulse width output
    // ****************************************************************
    duty_word = {s.cap[7:0], s.ctrl[`CCM_DUTY_HI:`CCM_DUTY_LO]};
    if (cl == CCM_CL_PWM) begin
      if (pulse_period_match) begin
        next_s.duty_latch = duty_word;
        next_s.pwm_out    = duty_word != `CCM_DUTY_ZERO;
      end else if (pulse_time_base == s.duty_latch) begin
        next_s.pwm_out = 1'b0;
      end
    end else begin
      next_s.pwm_out = 1'b0;
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    if (wr_commit) begin
      if (addr_hit(apb_req.paddr, `CCM_OFF_CTRL)) begin
        next_s.ctrl = apb_req.pwdata[`CCM_STORE_HI:0];
      end
      if (addr_hit(apb_req.paddr, `CCM_OFF_CAP_LOW)) begin
        next_s.cap[7:0] = apb_req.pwdata[7:0];
      end
      if (addr_hit(apb_req.paddr, `CCM_OFF_CAP_HIGH) && cl != CCM_CL_PWM) begin
        next_s.cap[15:8] = apb_req.pwdata[7:0];
      end
      if (addr_hit(apb_req.paddr, `CCM_OFF_FLAG) && apb_req.pwdata[`CCM_FLAG_BIT]) begin
        next_s.irq_flag = 1'b0;
      end
      if (addr_hit(apb_req.paddr, `CCM_OFF_ENABLE)) begin
        next_s.irq_en = apb_req.pwdata[`CCM_FLAG_BIT];
      end
    end

    // Duty high byte is reloaded each period
    if (cl == CCM_CL_PWM && pulse_period_match) begin
      next_s.cap[15:8] = s.cap[7:0];
    end

    // Capture beats a software write to the pair
    if (cap_event) begin
      next_s.cap = shared_timer_count;
    end

    // Hardware set wins over software clear
    if (cap_event || cmp_match) begin
      next_s.irq_flag = 1'b1;
    end

    // Turning off clears unit state
    if (wr_commit && addr_hit(apb_req.paddr, `CCM_OFF_CTRL) &&
        apb_req.pwdata[`CCM_MODE_HI:`CCM_MODE_LO] == `CCM_M_OFF) begin
      next_s.presc      = `CCM_PRE_RST;
      next_s.cmp_out    = 1'b0;
      next_s.pwm_out    = 1'b0;
      next_s.duty_latch = `CCM_DUTY_ZERO;
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    next_s.pin_oe = ~pin_direction_bit;
    unique case (cl)
      CCM_CL_COMPARE: begin
        if (mode == `CCM_M_CMP_SET || mode == `CCM_M_CMP_CLR) begin
          next_s.pin_out = s.cmp_out;
        end else begin
          next_s.pin_out = port_latch_value;
        end
      end
      CCM_CL_PWM: next_s.pin_out = s.pwm_out;
      default: next_s.pin_out = port_latch_value;
    endcase

    // ****************************************************************
    // Register reads and bus answer
    // ****************************************************************
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    unique case (apb_req.paddr)
      `CCM_OFF_CTRL: rd_byte = {2'b00, s.ctrl};
      `CCM_OFF_CAP_LOW: rd_byte = s.cap[7:0];
      `CCM_OFF_CAP_HIGH: rd_byte = s.cap[15:8];
      `CCM_OFF_FLAG: rd_byte = {7'h00, s.irq_flag};
      `CCM_OFF_ENABLE: rd_byte = {7'h00, s.irq_en};
      `CCM_OFF_STATUS: begin
        rd_byte[`CCM_ST_PIN_BIT]                = s.pin_sync;
        rd_byte[`CCM_ST_OUT_BIT]                = s.pin_out;
        rd_byte[`CCM_ST_PRE_HI:`CCM_ST_PRE_LO] = s.presc;
      end
      default: rd_hit = 1'b0;
    endcase

    next_s.rsp.pready = bus_setup;
    if (bus_setup) begin
      next_s.rsp.pslverr = ~rd_hit;
      next_s.rsp.prdata  = (apb_req.pwrite || !rd_hit) ? `CCM_RD_ZERO
                                                        : {`CCM_RD_PAD, rd_byte};
    end else begin
      next_s.rsp.pslverr = 1'b0;
      next_s.rsp.prdata  = `CCM_RD_ZERO;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign apb_rsp            = s.rsp;
  assign shared_timer_reset = s.tmr_rst;
  assign adc_start          = s.adc_go;
  assign event_pin_out      = s.pin_out;
  assign event_pin_oe       = s.pin_oe;
  assign unit_irq_flag      = s.irq_flag;
  assign unit_irq_enable    = s.irq_en;

endmodule // ccm_top

// [testbench/ccm_props.sv]
`timescale 1ns/10ps
module ccm_props (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst_b,
  // Watched ports
  input wire ccm_pkg::ccm_apb_req_s apb_req,
  input wire ccm_pkg::ccm_apb_rsp_s apb_rsp,
  input wire logic                  adc_enabled,
  input wire logic                  adc_start,
  input wire logic                  shared_timer_reset,
  input wire logic                  pin_direction_bit,
  input wire logic                  event_pin_oe,
  input wire logic                  unit_irq_flag
);
  import ccm_pkg::*;
  logic clr_wr;
  // Flag clear write committing now
  assign clr_wr = apb_rsp.pready && apb_req.pwrite && apb_req.paddr == 12'h00c
                  && apb_req.pwdata[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_err_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("error without ready");
  a_ready_one_wait: assert property (apb_req.psel && $rose(apb_req.penable) |=> apb_rsp.pready)
    else $error("ready late");
  a_ready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready too long");
  a_ctrl_top_zero: assert property (apb_rsp.pready && !apb_req.pwrite &&
    apb_req.paddr == 12'h000 |-> apb_rsp.prdata[31:6] == 26'h0)
    else $error("control top bits set");
  a_flag_sw_clear: assert property ($fell(unit_irq_flag) |-> $past(clr_wr))
    else $error("flag cleared by hardware");
  a_trig_sets_flag: assert property (shared_timer_reset |-> unit_irq_flag)
    else $error("trigger without flag");
  a_start_with_trig: assert property (adc_start |-> shared_timer_reset && $past(adc_enabled))
    else $error("conversion start without cause");
  a_oe_follow_dir: assert property ($past(rst_b) |-> event_pin_oe == !$past(pin_direction_bit))
    else $error("enable not following direction");
endmodule // ccm_props

// [testbench/ccm_pin_src.sv]
`timescale 1ns/10ps
module ccm_pin_src (
  // Clock
  input wire logic clk,
  // Design side of pin
  input wire logic pin_out,
  input wire logic pin_oe,
  // Resolved level
  output logic     pin
);
  logic lvl;
  initial lvl = 1'b0;
  // Design drive wins while enabled
  assign pin = pin_oe ? pin_out : lvl;
  task automatic drive(input logic v, input int hold);
    @(posedge clk);
    lvl <= v;
    repeat (hold) @(posedge clk);
  endtask
endmodule // ccm_pin_src

// [testbench/tb.sv]
`timescale 1ns/10ps
`include "ccm_cfg.svh"
module tb;
  import ccm_pkg::*;
  logic         clk, rst_b, ptm, adc_en, dir, plv, pin, tr, adc, po, poe, irq, irqe;
  logic [15:0]  tmr, t1, t2, c;
  logic [9:0]   ptb;
  ccm_apb_req_s req;
  ccm_apb_rsp_s rsp;
  logic [32:0]  exp_q[$];
  logic [11:0]  regs[6] = '{`CCM_OFF_CTRL, `CCM_OFF_CAP_LOW, `CCM_OFF_CAP_HIGH,
                          `CCM_OFF_FLAG, `CCM_OFF_ENABLE, `CCM_OFF_STATUS};
  int           n_errors, comparisons, seed, n_tr, n_adc, nh;
  int           npre[4] = '{0, 0, 3, 15};
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ccm_top uut (.clk, .rst_b, .apb_req(req), .apb_rsp(rsp), .shared_timer_count(tmr),
    .pulse_time_base(ptb), .pulse_period_match(ptm), .shared_timer_reset(tr),
    .adc_enabled(adc_en), .adc_start(adc), .event_pin_in(pin), .pin_direction_bit(dir),
    .port_latch_value(plv), .event_pin_out(po), .event_pin_oe(poe), .unit_irq_flag(irq),
    .unit_irq_enable(irqe));
  ccm_pin_src src (.clk, .pin_out(po), .pin_oe(poe), .pin);
  // ******
  // Shared tasks
  // ******
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("%0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    @(posedge clk);
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pulse();
    src.drive(1'b1, 4);
    src.drive(1'b0, 4);
  endtask
  // ******
  // Result watcher
  // ******
  always @(negedge clk) begin
    if (rsp.pready === 1'b1 && req.pwrite === 1'b0) begin
      if (exp_q.size() == 0) check(33'h0, 33'h1ffffffff);
      else check({rsp.pslverr, rsp.prdata}, exp_q.pop_front());
    end
    if (tr === 1'b1) n_tr++;
    if (adc === 1'b1) n_adc++;
  end
  // ******
  // Scenarios
  // ******
  initial begin
    seed = 56581;
    {rst_b, ptm, adc_en, plv, tmr, ptb, n_errors, comparisons, n_tr, n_adc, nh} = '0;
    req = '0;
    dir = 1'b1;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    foreach (regs[i]) rd(regs[i], 33'h0);
    rd(12'h018, 33'h100000000);
    wr(`CCM_OFF_CTRL, 32'hff);
    rd(`CCM_OFF_CTRL, 33'h3f);
    wr(`CCM_OFF_ENABLE, 32'h1);
    rd(`CCM_OFF_ENABLE, 33'h1);
    $display("register test done");
    for (int m = 4; m < 8; m++) begin
      wr(`CCM_OFF_CTRL, 32'h0);
      wr(`CCM_OFF_CTRL, 32'(m) | 32'h30);
      wr(`CCM_OFF_FLAG, 32'h1);
      for (int r = 0; r < 2; r++) begin
        t1 = 16'($random(seed));
        t2 = 16'($random(seed));
        tmr <= t1;
        repeat (npre[m-4]) pulse();
        rd(`CCM_OFF_FLAG, 33'(r));
        src.drive(1'b1, 6);
        tmr <= t2;
        src.drive(1'b0, 6);
      end
      rd(`CCM_OFF_CAP_LOW, {25'h0, (m == 4) ? t2[7:0] : t1[7:0]});
      rd(`CCM_OFF_CAP_HIGH, {25'h0, (m == 4) ? t2[15:8] : t1[15:8]});
      wr(`CCM_OFF_FLAG, 32'h1);
      rd(`CCM_OFF_FLAG, 33'h0);
    end
    repeat (5) pulse();
    rd(`CCM_OFF_STATUS, 33'h50);
    wr(`CCM_OFF_CTRL, 32'h0);
    rd(`CCM_OFF_STATUS, 33'h0);
    $display("capture test done");
    dir <= 1'b0;
    adc_en <= 1'b1;
    c = 16'($random(seed));
    tmr <= c + 16'h1;
    wr(`CCM_OFF_CAP_LOW, {24'h0, c[7:0]});
    wr(`CCM_OFF_CAP_HIGH, {24'h0, c[15:8]});
    for (int m = 8; m < 12; m++) begin
      plv <= (m == 11);
      wr(`CCM_OFF_FLAG, 32'h1);
      wr(`CCM_OFF_CTRL, 32'(m));
      @(posedge clk);
      tmr <= c;
      @(posedge clk);
      tmr <= c + 16'h2;
      repeat (3) @(posedge clk);
      rd(`CCM_OFF_FLAG, 33'h1);
      rd(`CCM_OFF_STATUS, {31'h0, {2{m == 8 || m == 11}}});
      check(33'(n_tr), 33'(m == 11));
      check(33'(n_adc), 33'(m == 11));
    end
    $display("compare test done");
    wr(`CCM_OFF_CAP_LOW, 32'h02);
    wr(`CCM_OFF_CTRL, 32'h1c);
    @(posedge clk);
    ptm <= 1'b1;
    ptb <= 10'h0;
    for (int k = 1; k < 30; k++) begin
      @(posedge clk);
      ptm <= 1'b0;
      ptb <= 10'((k < 20) ? k : 20);
      @(negedge clk);
      if (po === 1'b1) nh++;
    end
    check(33'(nh), 33'd9);
    rd(`CCM_OFF_CAP_HIGH, 33'h02);
    $display("pulse test done");
    conclude();
  end
endmodule // tb
bind ccm_top ccm_props u_props (.clk, .rst_b, .apb_req, .apb_rsp, .adc_enabled, .adc_start,
  .shared_timer_reset, .pin_direction_bit, .event_pin_oe, .unit_irq_flag);
